// [rtl/cms_consts.vh]
// Constants of the coprocessor misc/status/timer block.
// Assumes inclusion by cms_top.v and by the port checker.
`ifndef CMS_CONSTS_VH
`define CMS_CONSTS_VH
// APB register byte offsets
`define CMS_ADDR_STATUS   8'h00
`define CMS_ADDR_TOD_LO   8'h04
`define CMS_ADDR_TOD_HI   8'h08
`define CMS_ADDR_FRAC_LO  8'h0c
`define CMS_ADDR_FRAC_HI  8'h10
`define CMS_ADDR_EXP      8'h14
`define CMS_ADDR_ALARM_LO 8'h18
`define CMS_ADDR_ALARM_HI 8'h1c
// Status register bit positions
`define CMS_ST_SIGN  31
`define CMS_ST_NZ    30
`define CMS_ST_ABORT 5
`define CMS_ST_DRNG  4
`define CMS_ST_SRNG  3
`define CMS_ST_RSV   2
`define CMS_ST_ZDIV  1
`define CMS_ST_INT   0
// Operation codes on the instruction port
`define CMS_OP_NOP        4'h0
`define CMS_OP_FIX        4'h1
`define CMS_OP_FLOAT_S    4'h2
`define CMS_OP_FLOAT_D    4'h3
`define CMS_OP_SCALE      4'h4
`define CMS_OP_SET_EXP    4'h5
`define CMS_OP_SET_SIGN   4'h6
`define CMS_OP_READ_CLOCK 4'h7
`define CMS_OP_SET_ALARM  4'h8
`define CMS_OP_SET_CLOCK  4'h9
`define CMS_OP_INT_DIV    4'ha
`define CMS_OP_LOAD_FIX   4'hb
`define CMS_OP_LOAD_S     4'hc
`define CMS_OP_FDIV_S     4'hd
// Result formats
`define CMS_RES_NONE   2'h0
`define CMS_RES_SINGLE 2'h1
`define CMS_RES_DOUBLE 2'h2
`define CMS_RES_FRAC   2'h3
// Exponent ranges and biases
`define CMS_S_EMIN  16'hff81
`define CMS_S_EMAX  16'h007f
`define CMS_D_EMIN  16'hfc01
`define CMS_D_EMAX  16'h03ff
`define CMS_S_BIAS  16'h0080
`define CMS_D_BIAS  16'h0400
// Fraction bits kept after rounding, hidden bit included
`define CMS_S_KEEP  7'd24
`define CMS_D_KEEP  7'd53
// Alarm reach in cycles
`define CMS_ALARM_SPAN 64'h0000_0000_0008_0000
`endif

// [rtl/cms_top.v]
// Coprocessor misc functions, status register and time-of-day timer.
// Assumes an APB master on pclk and a host issuing one instruction per
// ins_valid pulse, synchronous to pclk.
// Functional notes
// - Integer divide: quotient low, remainder high
// - Fix shifts point right of bit 63, negates
// - Fixed pair converts to float, rounds per format
// - Scale adds exponent; set-exponent replaces it
// - Set-sign copies source bit 0
// - Read-clock puts time count in fraction
// - Kernel set-alarm loads alarm; user ignored
// - Kernel set-clock loads time, drops alarm, interrupts
// - 64-bit time count increments every cycle
// - Alarm within reach fires when time matches
// - Kernel mode masks interrupt; alarm write clears
// - Float divide by zero traps, accumulator untouched
// - Reserved operand traps, operation skipped
// - Range error only on unrepresentable requested result
// - Status field order sign down to timer
// - Range flags live; abort plus flag means error
// - Every instruction clears abort unless it traps
// - Status write loads sign, reserved and zero-divide flags, clears abort
// - Timer pending bit is sticky: set by alarm hit or set-clock, cleared only by kernel alarm write
// - Double fixed operations raise no exception
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "cms_consts.vh"
module cms_top
(
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Coprocessor instruction port
	input  wire        ins_valid,
	input  wire [3:0]  ins_op,
	input  wire [1:0]  ins_res_fmt,
	input  wire        ins_kernel,
	input  wire [31:0] ins_src_a,
	input  wire [31:0] ins_src_b,
	output reg  [31:0] ins_result,
	output reg         ins_trap,
	// Timer interrupt toward the processor
	output reg         timer_irq
);

	// Leading one position of a 64-bit word
	function [5:0] lead_one;
		input [63:0] v;
		integer i;
		begin
			lead_one = 6'h00;
			for (i = 0; i < 64; i = i + 1)
				if (v[i])
					lead_one = i[5:0];
		end
	endfunction
	// Round half up keeping the top bits below bit 63
	function [64:0] round_frac;
		input [63:0] f;
		input [6:0]  keep;
		reg   [63:0] half;
		reg   [63:0] mask;
		reg   [64:0] sum;
		begin
			half = 64'h1 << (7'd62 - keep);
			mask = ~((half << 1) - 64'h1);
			sum = {1'b0, f} + {1'b0, half};
			round_frac = {sum[64], sum[63:0] & mask};
		end
	endfunction
	// Exponent outside a signed range
	function out_range;
		input [15:0] e;
		input [15:0] lo;
		input [15:0] hi;
		begin
			out_range = ($signed(e) < $signed(lo)) || ($signed(e) > $signed(hi));
		end
	endfunction
	// Accumulator and timer state
	reg        sign_r;
	reg [15:0] exp_r;
	reg [63:0] frac_r;
	reg [63:0] tod_r;
	reg [63:0] alarm_r;
	reg        armed_r;
	reg        pend_r;
	reg        rsv_r;
	reg        zdiv_r;
	reg        abort_r;
	reg        sign_nxt;
	reg [15:0] exp_nxt;
	reg [63:0] frac_nxt;
	reg [63:0] tod_nxt;
	reg [63:0] alarm_nxt;
	reg        armed_nxt;
	reg        pend_nxt;
	reg        rsv_nxt;
	reg        zdiv_nxt;
	reg        abort_nxt;
	reg        trap_nxt;
	reg [31:0] result_nxt;
	// Scratch for the conversions
	reg [63:0] fixed_in;
	reg [63:0] mag;
	reg [5:0]  lead;
	reg [63:0] norm;
	reg [64:0] rnd;
	reg [6:0]  shamt;
	reg [63:0] shifted;
	reg [63:0] alarm_dist;
	reg        range_s;
	reg        range_d;
	reg        a_zero;
	reg        a_rsv;
	// Full-width divide; only the low words are kept
	wire [63:0] quot_w = frac_r / {32'h0, ins_src_a};
	wire [63:0] rem_w  = frac_r % {32'h0, ins_src_a};
	wire [15:0] exp_s = exp_r + `CMS_S_BIAS;
	wire [15:0] exp_d = exp_r + `CMS_D_BIAS;
	// Live range flags of the accumulator
	wire        frac_nz = |frac_r;
	wire        srng = frac_nz && out_range(exp_r, `CMS_S_EMIN, `CMS_S_EMAX);
	wire        drng = frac_nz && out_range(exp_r, `CMS_D_EMIN, `CMS_D_EMAX);
	// Status word, sign first down to the timer bit
	wire [31:0] status_word = {sign_r, frac_nz, 24'h000000, abort_r, drng, srng,
		rsv_r, zdiv_r, pend_r};
	// Bus write strobe and alarm match
	wire        apb_wr = psel && penable && pwrite && pready;
	wire        st_wr  = apb_wr && (paddr == `CMS_ADDR_STATUS);
	wire        alarm_hit = armed_r && (tod_r == alarm_r);

	// Instruction execution, timer and status updates
	always @*
	begin
		sign_nxt = sign_r;
		exp_nxt = exp_r;
		frac_nxt = frac_r;
		tod_nxt = tod_r + 64'h1;
		alarm_nxt = alarm_r;
		armed_nxt = armed_r;
		pend_nxt = pend_r;
		rsv_nxt = rsv_r;
		zdiv_nxt = zdiv_r;
		abort_nxt = abort_r;
		trap_nxt = 1'b0;
		result_nxt = ins_result;
		fixed_in = {ins_src_a, ins_src_b};
		mag = fixed_in[63] ? (~fixed_in + 64'h1) : fixed_in;
		lead = lead_one(mag);
		norm = mag << (6'd62 - lead);
		rnd = 65'h0;
		shamt = 7'd63 - exp_r[6:0];
		shifted = frac_r >> shamt;
		alarm_dist = fixed_in - tod_r;
		range_s = 1'b0;
		range_d = 1'b0;
		a_zero = (ins_src_a[30:23] == 8'h00) && !ins_src_a[31];
		a_rsv = (ins_src_a[30:23] == 8'h00) && ins_src_a[31];
		// Alarm hit while armed
		if (alarm_hit)
		begin
			pend_nxt = 1'b1;
			armed_nxt = 1'b0;
		end
		// Status write from software
		if (st_wr)
		begin
			sign_nxt = pwdata[`CMS_ST_SIGN];
			rsv_nxt = pwdata[`CMS_ST_RSV];
			zdiv_nxt = pwdata[`CMS_ST_ZDIV];
			abort_nxt = 1'b0;
		end
		if (ins_valid)
		begin
			abort_nxt = 1'b0;
			// Previous result, range checked in the requested format
			case (ins_res_fmt)
				`CMS_RES_SINGLE:
				begin
					result_nxt = {sign_r, exp_s[7:0], frac_r[61:39]};
					range_s = srng;
				end
				`CMS_RES_DOUBLE:
				begin
					result_nxt = {sign_r, exp_d[10:0], frac_r[61:42]};
					range_d = drng;
				end
				`CMS_RES_FRAC:
					result_nxt = frac_r[63:32];
				default:
					result_nxt = 32'h00000000;
			endcase
			if (range_s || range_d)
			begin
				abort_nxt = 1'b1;
				trap_nxt = 1'b1;
			end
			else
			begin
				case (ins_op)
					`CMS_OP_INT_DIV:
						frac_nxt = {rem_w[31:0], quot_w[31:0]};
					`CMS_OP_FIX:
					begin
						if ($signed(exp_r) > $signed(16'h003f))
							shifted = 64'h0;
						else if ($signed(exp_r) < $signed(16'h0000))
							shifted = 64'h0;
						frac_nxt = sign_r ? (~shifted + 64'h1) : shifted;
					end
					`CMS_OP_FLOAT_S, `CMS_OP_FLOAT_D:
					begin
						rnd = round_frac(norm, (ins_op == `CMS_OP_FLOAT_S) ?
							`CMS_S_KEEP : `CMS_D_KEEP);
						sign_nxt = fixed_in[63];
						if (mag == 64'h0)
						begin
							sign_nxt = 1'b0;
							exp_nxt = 16'h0000;
							frac_nxt = 64'h0;
						end
						else
						begin
							// Rounding carry out renormalises by one place
							frac_nxt = rnd[63] ? rnd[64:1] : rnd[63:0];
							exp_nxt = {10'h000, lead} - (rnd[63] ? 16'd30 : 16'd31);
						end
					end
					`CMS_OP_SCALE:
						exp_nxt = exp_r + ins_src_a[15:0];
					`CMS_OP_SET_EXP:
						exp_nxt = ins_src_a[15:0];
					`CMS_OP_SET_SIGN:
						sign_nxt = ins_src_a[0];
					`CMS_OP_READ_CLOCK:
						frac_nxt = tod_r;
					`CMS_OP_SET_ALARM:
						if (ins_kernel)
						begin
							alarm_nxt = fixed_in;
							armed_nxt = (alarm_dist != 64'h0) &&
								(alarm_dist < `CMS_ALARM_SPAN);
							pend_nxt = alarm_hit;
						end
					`CMS_OP_SET_CLOCK:
						if (ins_kernel)
						begin
							tod_nxt = fixed_in;
							armed_nxt = 1'b0;
							pend_nxt = 1'b1;
						end
					`CMS_OP_LOAD_FIX:
					begin
						frac_nxt = fixed_in;
						sign_nxt = ins_src_a[31];
					end
					`CMS_OP_LOAD_S, `CMS_OP_FDIV_S:
						// Reserved operand or zero divisor traps before any change
						if (a_rsv || (a_zero && ins_op == `CMS_OP_FDIV_S))
						begin
							rsv_nxt = rsv_r || a_rsv;
							zdiv_nxt = zdiv_r || !a_rsv;
							abort_nxt = 1'b1;
							trap_nxt = 1'b1;
						end
						else if (ins_op == `CMS_OP_LOAD_S)
						begin
							// Zero loads clear all three fields
							sign_nxt = ins_src_a[31];
							exp_nxt = a_zero ? 16'h0000 :
								{8'h00, ins_src_a[30:23]} - `CMS_S_BIAS;
							frac_nxt = a_zero ? 64'h0 : {2'b01, ins_src_a[22:0], 39'h0};
						end
					default:
						frac_nxt = frac_r;
				endcase
			end
		end
	end
	// State registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sign_r <= 1'b0;
			exp_r <= 16'h0000;
			frac_r <= 64'h0;
			tod_r <= 64'h0;
			alarm_r <= 64'h0;
			armed_r <= 1'b0;
			pend_r <= 1'b0;
			rsv_r <= 1'b0;
			zdiv_r <= 1'b0;
			abort_r <= 1'b0;
			ins_trap <= 1'b0;
			ins_result <= 32'h00000000;
			timer_irq <= 1'b0;
		end
		else
		begin
			sign_r <= sign_nxt;
			exp_r <= exp_nxt;
			frac_r <= frac_nxt;
			tod_r <= tod_nxt;
			alarm_r <= alarm_nxt;
			armed_r <= armed_nxt;
			pend_r <= pend_nxt;
			rsv_r <= rsv_nxt;
			zdiv_r <= zdiv_nxt;
			abort_r <= abort_nxt;
			ins_trap <= trap_nxt;
			ins_result <= result_nxt;
			timer_irq <= pend_r && !ins_kernel;
		end
	end
	// APB read mux
	reg [31:0] rd_mux;
	reg        rd_err;
	always @*
	begin
		rd_err = 1'b0;
		case (paddr)
			`CMS_ADDR_STATUS:   rd_mux = status_word;
			`CMS_ADDR_TOD_LO:   rd_mux = tod_r[31:0];
			`CMS_ADDR_TOD_HI:   rd_mux = tod_r[63:32];
			`CMS_ADDR_FRAC_LO:  rd_mux = frac_r[31:0];
			`CMS_ADDR_FRAC_HI:  rd_mux = frac_r[63:32];
			`CMS_ADDR_EXP:      rd_mux = {16'h0000, exp_r};
			`CMS_ADDR_ALARM_LO: rd_mux = alarm_r[31:0];
			`CMS_ADDR_ALARM_HI: rd_mux = alarm_r[63:32];
			default:
			begin
				rd_mux = 32'h00000000;
				rd_err = 1'b1;
			end
		endcase
	end
	// APB handshake: ready in the first access cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && rd_err;
			if (psel && !penable && !pwrite)
				prdata <= rd_mux;
		end
	end

endmodule

// [sim/cms_host_model.sv]
// Host processor model driving the instruction port.
// Assumes run is called just after a rising pclk edge.
`timescale 1ns/1ps
module cms_host_model
(
	// Clock
	input  wire        pclk,
	// Instruction port
	output reg         ins_valid,
	output reg  [3:0]  ins_op,
	output reg  [1:0]  ins_res_fmt,
	output reg         ins_kernel,
	output reg  [31:0] ins_src_a,
	output reg  [31:0] ins_src_b
);
	// Idle in kernel mode at time zero
	initial
	begin
		{ins_valid, ins_op, ins_res_fmt} = 7'h0;
		{ins_kernel, ins_src_a, ins_src_b} = {1'b1, 64'h0};
	end
	// One op, a gap cycle, sources scrambled once released
	task run(input [3:0] o, input [1:0] f, input k, input [31:0] a, input [31:0] b);
	begin
		{ins_valid, ins_op, ins_res_fmt, ins_kernel} <= {1'b1, o, f, k};
		{ins_src_a, ins_src_b} <= {a, b};
		@(posedge pclk);
		ins_valid <= 1'b0;
		{ins_src_a, ins_src_b} <= ~{a, b};
		@(posedge pclk);
	end
	endtask
endmodule

// [sim/cms_top_props.sv]
// Port checker for cms_top.
// Assumes one pclk domain reset by presetn.
`timescale 1ns/1ps
`include "cms_consts.vh"
module cms_top_props
(
	// Clock, reset and APB
	input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	// Instruction port and interrupt
	input wire        ins_valid, ins_kernel, ins_trap, timer_irq,
	input wire [3:0]  ins_op,
	input wire [1:0]  ins_res_fmt,
	input wire [31:0] ins_src_a, ins_result
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held");
	a_err_unmapped: assert property (psel && !penable && paddr > 8'h1c |=> pslverr && pready)
		else $error("unmapped access accepted");
	a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("data on refused read");
	// Instruction outcomes
	a_trap_has_cause: assert property (ins_trap |-> $past(ins_valid))
		else $error("trap without instruction");
	a_zero_div_traps: assert property (ins_valid && ins_op == `CMS_OP_FDIV_S && ins_src_a == 32'h0 |=> ins_trap)
		else $error("divide by zero missed");
	a_dfix_no_trap: assert property (ins_valid && ins_op == `CMS_OP_LOAD_FIX && ins_res_fmt == 2'h0 |=> !ins_trap)
		else $error("double fixed op trapped");
	a_plain_no_trap: assert property (ins_valid && ins_op == `CMS_OP_NOP && ins_res_fmt == 2'h0 |=> !ins_trap)
		else $error("trap with no result asked");
	a_kernel_masks: assert property (ins_kernel |=> !timer_irq)
		else $error("interrupt in kernel mode");
	a_result_holds: assert property (!ins_valid |=> $stable(ins_result))
		else $error("result moved while idle");
endmodule
bind cms_top cms_top_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.paddr(paddr), .prdata(prdata), .ins_valid(ins_valid), .ins_kernel(ins_kernel),
	.ins_trap(ins_trap), .timer_irq(timer_irq), .ins_op(ins_op),
	.ins_res_fmt(ins_res_fmt), .ins_src_a(ins_src_a), .ins_result(ins_result));

// [sim/test_cms_top.sv]
// Bench for cms_top: APB accesses, host instructions, checks.
// Assumes the host model and the bound checker are compiled in.
`timescale 1ns/1ps
module test_cms_top;
	// APB side, observed outputs, counters
	reg         pclk, presetn, psel, penable, pwrite, err;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, q;
	wire [31:0] prdata, ins_src_a, ins_src_b, ins_result;
	wire        pready, pslverr, ins_valid, ins_kernel, ins_trap, timer_irq;
	wire [3:0]  ins_op;
	wire [1:0]  ins_res_fmt;
	integer     n_fail, num_checks, cyc, traps;
	cms_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ins_valid(ins_valid), .ins_op(ins_op),
		.ins_res_fmt(ins_res_fmt), .ins_kernel(ins_kernel), .ins_src_a(ins_src_a),
		.ins_src_b(ins_src_b), .ins_result(ins_result), .ins_trap(ins_trap),
		.timer_irq(timer_irq));
	cms_host_model h (.pclk(pclk), .ins_valid(ins_valid), .ins_op(ins_op),
		.ins_res_fmt(ins_res_fmt), .ins_kernel(ins_kernel), .ins_src_a(ins_src_a),
		.ins_src_b(ins_src_b));
	// 250 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Trap count and hang guard, off the sampling edge
	always @(negedge pclk)
	begin
		cyc = cyc + 1;
		traps = traps + (ins_trap === 1'b1);
		if (cyc > 4000)
		begin
			n_fail = n_fail + 1;
			tally_and_finish;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask
	// Setup, access held until pready, then release
	task apb(input w, input [7:0] a, input [31:0] d);
	begin
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		{q, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	end
	endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] e);
	begin
		apb(1'b0, a, 32'h0);
		chk(q & m, e);
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// Main sequence
	initial
	begin
		{n_fail, num_checks, cyc, traps} = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(0, '1, 0);
		rd(8'h20, '1, 0);
		chk(err, 1);
		apb(1, 0, '1);
		rd(0, '1, 32'h80000006);
		apb(1, 0, 0);
		h.run(4'hb, 0, 1, 0, 100);
		h.run(4'ha, 0, 1, 7, 0);
		rd(8'h0c, '1, 14);
		rd(8'h10, '1, 2);
		chk(traps, 0);
		h.run(4'hd, 0, 1, 0, 0);
		chk(traps, 1);
		rd(8'h0c, '1, 14);
		rd(0, 32'h27, 32'h22);
		h.run(4'h0, 0, 1, 0, 0);
		rd(0, 32'h20, 0);
		h.run(4'hc, 0, 1, 32'h80000000, 0);
		chk(traps, 2);
		rd(0, 32'h24, 32'h24);
		apb(1, 0, 0);
		rd(0, 32'h27, 0);
		h.run(4'hc, 0, 1, 32'hc0800000, 0);
		h.run(4'h1, 0, 1, 0, 0);
		rd(8'h0c, '1, '1);
		rd(8'h10, '1, '1);
		h.run(4'h2, 0, 1, 3, 0);
		rd(8'h14, 32'hffff, 2);
		rd(8'h10, '1, 32'h60000000);
		h.run(4'h3, 0, 1, 0, 32'hffffffff);
		rd(8'h14, 32'hffff, 0);
		rd(8'h10, '1, 32'h7fffffff);
		h.run(4'h2, 0, 1, 0, 32'hffffffff);
		rd(8'h14, 32'hffff, 1);
		rd(8'h10, '1, 32'h40000000);
		h.run(4'h5, 0, 1, 5, 0);
		h.run(4'h4, 0, 1, 3, 0);
		rd(8'h14, 32'hffff, 8);
		h.run(4'h6, 0, 1, 1, 0);
		rd(0, 32'h80000000, 32'h80000000);
		h.run(4'h5, 0, 1, 200, 0);
		rd(0, 32'h18, 32'h08);
		h.run(4'h0, 2, 1, 0, 0);
		chk(traps, 2);
		h.run(4'h0, 1, 1, 0, 0);
		chk(traps, 3);
		rd(0, 32'h28, 32'h28);
		h.run(4'h5, 0, 1, 2000, 0);
		h.run(4'h0, 2, 1, 0, 0);
		chk(traps, 4);
		rd(0, 32'h38, 32'h38);
		h.run(4'h5, 0, 1, 32'hff81, 0);
		rd(0, 32'h18, 0);
		h.run(4'h5, 0, 1, 32'hff80, 0);
		rd(0, 32'h18, 32'h08);
		h.run(4'h9, 0, 1, 32'habc, 0);
		rd(0, 1, 1);
		chk(timer_irq, 0);
		rd(8'h08, '1, 32'habc);
		h.run(4'h7, 0, 1, 0, 0);
		h.run(4'h0, 3, 1, 0, 0);
		chk(ins_result, 32'habc);
		apb(0, 8'h04, 0);
		rd(8'h04, '1, q + 3);
		h.run(4'h9, 0, 0, 5, 0);
		chk(timer_irq, 1);
		h.run(4'h8, 0, 0, 0, 0);
		rd(8'h08, '1, 32'habc);
		rd(0, 1, 1);
		apb(0, 8'h04, 0);
		h.run(4'h8, 0, 1, 32'habc, q + 200);
		rd(0, 1, 0);
		repeat (250) @(posedge pclk);
		rd(0, 1, 1);
		apb(0, 8'h04, 0);
		h.run(4'h8, 0, 1, 32'habc, q + 32'h80009);
		repeat (250) @(posedge pclk);
		rd(0, 1, 0);
		tally_and_finish;
	end
endmodule
